//--- pcm_clock_ctrl.sv
// PLL clock control: ratio and status registers, mode sequencing.
// Assumes clk is the oscillator clock; rst is external pin or watchdog.
// Operation
// - Four-bit ratio field selects core clock multiplier from oscillator.
// - Reset and zero ratio give bypass; PLL stays powered, output unused.
// - Ratio 1 to 10 multiplies then post-divides; 11 to 15 reserved.
// - Divide select 0,1 give /4, 2 gives /2, 3 gives /1 (held at /2 in enabled mode); reset /4.
// - Ratio write forces bypass until lock, then multiplied clock applies.
// - Power-down bit disables PLL; core clock is input through divider.
// - Registers reset only by external reset pin or watchdog reset.
// - Control writes take effect only while protected write gate open.
// - Clock source is crystal oscillator or external clock, oscillator off.
`timescale 1ns/1ps
module pcm_clock_ctrl #(
  parameter int unsigned LOCK_CYCLES = pcm_pkg::LOCK_OSC_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       protected_write_gate,
  input  wire logic                       ratio_write,
  input  wire logic [3:0]                 ratio_wdata,
  input  wire logic                       status_write,
  input  wire pcm_pkg::pcm_status_type    status_wdata,
  input  wire logic                       external_clock_select,
  output logic [3:0]                      pll_ratio_control,
  output pcm_pkg::pcm_status_type         pll_status_reg,
  output logic                            lock_flag,
  output logic                            pll_powered,
  output logic                            internal_osc_enable,
  output pcm_pkg::pcm_clock_cfg_type      core_clock_cfg
);

  function automatic logic [2:0] div_of(input logic [1:0] sel);
    if (sel == pcm_pkg::POSTDIV_DIV1) begin
      div_of = pcm_pkg::DIV_BY_1;
    end else if (sel == pcm_pkg::POSTDIV_DIV2) begin
      div_of = pcm_pkg::DIV_BY_2;
    end else begin
      div_of = pcm_pkg::DIV_BY_4;
    end
  endfunction

  function automatic logic ratio_ok(input logic [3:0] r);
    ratio_ok = r != pcm_pkg::RATIO_BYPASS && r <= pcm_pkg::RATIO_MAX;
  endfunction

  logic                       ext_sync1_reg;
  logic                       ext_sync2_reg;
  logic [3:0]                 ratio_reg;
  logic [3:0]                 ratio_next;
  pcm_pkg::pcm_status_type    status_reg;
  pcm_pkg::pcm_status_type    status_next;
  pcm_pkg::pcm_mode_type      state_reg;
  pcm_pkg::pcm_mode_type      state_next;
  pcm_pkg::pcm_clock_cfg_type cfg_reg;
  pcm_pkg::pcm_clock_cfg_type cfg_next;
  logic                       powered_reg;
  logic                       powered_next;
  logic                       osc_en_reg;
  logic                       osc_en_next;
  logic                       ratio_accept;
  logic                       status_accept;
  logic                       locked;
  logic                       ratio_usable;

  // Register writes
  always_comb begin
    ratio_accept  = ratio_write && protected_write_gate;
    status_accept = status_write && protected_write_gate;
    ratio_next    = ratio_reg;
    status_next   = status_reg;
    if (ratio_accept) begin
      ratio_next = ratio_wdata;
    end
    if (status_accept) begin
      status_next = status_wdata;
    end
  end

  // Only rst touches these: debugger and missing-clock resets stay outside
  always_ff @(posedge clk) begin
    if (rst) begin
      ratio_reg                      <= pcm_pkg::RATIO_RESET;
      status_reg.pll_power_down_bit  <= pcm_pkg::PWRDN_RESET;
      status_reg.post_divider_select <= pcm_pkg::POSTDIV_RESET;
    end else begin
      ratio_reg  <= ratio_next;
      status_reg <= status_next;
    end
  end

  // Power-down or a fresh ratio write throws away any earlier lock
  pcm_lock_counter #(
    .COUNT (LOCK_CYCLES)
  ) u_lock (
    .clk     (clk),
    .rst     (rst),
    .restart (ratio_accept || status_reg.pll_power_down_bit),
    .enable  (!status_reg.pll_power_down_bit),
    .locked  (locked)
  );

  // Reserved ratios are kept in bypass rather than trusted
  assign ratio_usable = ratio_ok(ratio_reg);

  // Mode follows the incoming ratio so a write drops straight to locking
  always_comb begin
    if (status_reg.pll_power_down_bit) begin
      state_next = pcm_pkg::PCM_OFF;
    end else if (!ratio_ok(ratio_next)) begin
      state_next = pcm_pkg::PCM_BYPASS;
    end else if (ratio_accept || !locked) begin
      state_next = pcm_pkg::PCM_LOCKING;
    end else begin
      state_next = pcm_pkg::PCM_ENABLED;
    end
  end

  // Core clock setting and source control
  always_comb begin
    cfg_next.mode       = state_reg;
    cfg_next.multiplier = 4'h0;
    cfg_next.divider    = div_of(status_reg.post_divider_select);
    powered_next        = !status_reg.pll_power_down_bit;
    osc_en_next         = !ext_sync2_reg;
    case (state_reg)
      pcm_pkg::PCM_ENABLED: begin
        cfg_next.multiplier = ratio_reg;
        // Divide by one would skew the duty cycle; hold at two
        if (status_reg.post_divider_select == pcm_pkg::POSTDIV_DIV1) begin
          cfg_next.divider = pcm_pkg::DIV_BY_2;
        end
      end
      default: begin
        cfg_next.multiplier = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      state_reg     <= pcm_pkg::PCM_BYPASS;
      cfg_reg       <= {pcm_pkg::PCM_BYPASS, 4'h0, pcm_pkg::DIV_BY_4};
      powered_reg   <= 1'b1;
      osc_en_reg    <= 1'b1;
    end else begin
      ext_sync1_reg <= external_clock_select;
      ext_sync2_reg <= ext_sync1_reg;
      state_reg     <= state_next;
      cfg_reg       <= cfg_next;
      powered_reg   <= powered_next;
      osc_en_reg    <= osc_en_next;
    end
  end

  assign pll_ratio_control   = ratio_reg;
  assign pll_status_reg      = status_reg;
  assign lock_flag           = locked;
  assign pll_powered         = powered_reg;
  assign internal_osc_enable = osc_en_reg;
  assign core_clock_cfg      = cfg_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  gated_ratio_write_a: assert property (
    ratio_write && !protected_write_gate && !status_write
    |=> $stable(ratio_reg) && $stable(status_reg))
    else $error("write changed a register with gate closed");

  write_forces_bypass_a: assert property (
    ratio_accept && ratio_wdata != 4'h0 && ratio_wdata <= 4'hA
    && !status_reg.pll_power_down_bit && !status_accept
    |=> state_reg == pcm_pkg::PCM_LOCKING ##1
        core_clock_cfg.multiplier == 4'h0)
    else $error("ratio write did not fall back to bypass");

  write_clears_lock_a: assert property (
    ratio_accept |=> !lock_flag)
    else $error("lock flag survived a ratio write");

  zero_ratio_bypass_a: assert property (
    ratio_next == 4'h0 && !status_reg.pll_power_down_bit
    |=> state_reg == pcm_pkg::PCM_BYPASS)
    else $error("zero ratio left bypass");

  power_down_off_a: assert property (
    status_reg.pll_power_down_bit
    |=> state_reg == pcm_pkg::PCM_OFF && !pll_powered)
    else $error("power-down bit did not stop the PLL");

  reserved_ratio_bypass_a: assert property (
    ratio_reg > pcm_pkg::RATIO_MAX |=> core_clock_cfg.multiplier == 4'h0)
    else $error("reserved ratio produced a multiplied clock");

  lock_before_enable_a: assert property (
    !lock_flag |=> core_clock_cfg.mode != pcm_pkg::PCM_ENABLED)
    else $error("multiplied clock applied before lock");

  divider_map_a: assert property (
    state_reg != pcm_pkg::PCM_ENABLED
    |=> core_clock_cfg.divider == div_of($past(status_reg.post_divider_select)))
    else $error("post divider does not match divide select");

  enabled_multiplier_a: assert property (
    state_reg == pcm_pkg::PCM_ENABLED
    |=> core_clock_cfg.multiplier == $past(ratio_reg)
        && core_clock_cfg.mode == pcm_pkg::PCM_ENABLED)
    else $error("enabled mode lost the ratio multiplier");

  lock_enables_pll_a: assert property (
    $rose(lock_flag) && ratio_usable && !ratio_accept && !status_accept
    && !status_reg.pll_power_down_bit
    |=> state_reg == pcm_pkg::PCM_ENABLED)
    else $error("lock did not apply the multiplied clock");

  source_select_a: assert property (
    1'b1 |=> internal_osc_enable == !$past(ext_sync2_reg))
    else $error("oscillator enable not following source select");

endmodule

//--- pcm_clock_ctrl_tb.sv
// Self-checking bench of the PLL clock control block.
// Assumes a shortened lock count; clk stands for the oscillator clock.
`timescale 1ns/1ps
module pcm_clock_ctrl_tb;
  localparam int unsigned LC = 16;
  logic                       clk, rst, gate, rw, sw, ext_req, ext_sel;
  logic [3:0]                 rdata, ratio, n;
  logic [1:0]                 sel;
  pcm_pkg::pcm_status_type    sdata, stat;
  logic                       lock, powered, osc_en;
  pcm_pkg::pcm_clock_cfg_type cfg;
  int                         err_count, checks_done, k;
  logic [31:0]                seed;

  pcm_osc_model pcm_osc_model_inst (.source_is_external(ext_req),
    .external_clock_select(ext_sel));
  pcm_clock_ctrl #(.LOCK_CYCLES(LC)) pcm_clock_ctrl_inst (.clk(clk),
    .rst(rst), .protected_write_gate(gate), .ratio_write(rw),
    .ratio_wdata(rdata), .status_write(sw), .status_wdata(sdata),
    .external_clock_select(ext_sel), .pll_ratio_control(ratio),
    .pll_status_reg(stat), .lock_flag(lock), .pll_powered(powered),
    .internal_osc_enable(osc_en), .core_clock_cfg(cfg));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [2:0] exp_div(input logic [1:0] s, input logic en);
    if (s < 2'h2) return pcm_pkg::DIV_BY_4;
    if (s == 2'h2 || en) return pcm_pkg::DIV_BY_2;
    return pcm_pkg::DIV_BY_1;
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic wr_ratio(input logic [3:0] v);
    @(posedge clk);
    rw <= 1'b1;
    rdata <= v;
    @(posedge clk);
    rw <= 1'b0;
  endtask

  task automatic wr_stat(input logic pd, input logic [1:0] s);
    @(posedge clk);
    sw <= 1'b1;
    sdata <= {pd, s};
    @(posedge clk);
    sw <= 1'b0;
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(ratio, 16'h0000);
    chk(stat, 16'h0000);
    chk({lock, powered, osc_en}, 16'h0003);
    chk(cfg, {pcm_pkg::PCM_BYPASS, 4'h0, pcm_pkg::DIV_BY_4});
    $display("test reset done");
  endtask

  task automatic lock_to(input logic [3:0] v, input logic [1:0] s);
    int i;
    wr_stat(1'b0, 2'h0);
    wr_ratio(v);
    tick(2);
    chk(cfg, {pcm_pkg::PCM_LOCKING, 4'h0, pcm_pkg::DIV_BY_4});
    chk(ratio, v);
    i = 2;
    while (lock !== 1'b1 && i < 200) begin
      tick(1);
      i++;
    end
    if (i >= 200) begin
      err_count++;
      $display("CHECK FAILED at %0t: no lock", $time);
      test_done();
    end
    chk(16'(i), 16'(LC));
    tick(2);
    chk(cfg, {pcm_pkg::PCM_ENABLED, v, pcm_pkg::DIV_BY_4});
    wr_stat(1'b0, s);
    tick(3);
    chk(cfg.divider, exp_div(s, 1'b1));
    $display("test lock ratio %0d done", v);
  endtask

  initial begin
    seed = 32'h0000_0022;
    {rst, gate, rw, sw, ext_req} = 5'h00;
    rdata = 4'h0;
    sdata = 3'h0;
    do_reset();
    wr_ratio(4'h5);
    wr_stat(1'b1, 2'h2);
    tick(3);
    chk({ratio, 1'b0, stat}, 16'h0000);
    $display("test closed gate done");
    @(posedge clk);
    gate <= 1'b1;
    for (k = 0; k < 4; k++) begin
      // Nominal 30 MHz oscillator keeps ratio 10 inside the VCO limit
      n = (k == 0) ? 4'h1 : (k == 1) ? 4'hA : 4'(xs() % 10 + 1);
      sel = 2'(xs() % 3);
      lock_to(n, sel);
    end
    wr_stat(1'b0, 2'h0);
    wr_ratio(4'hB);
    tick(LC + 6);
    chk(cfg, {pcm_pkg::PCM_BYPASS, 4'h0, pcm_pkg::DIV_BY_4});
    wr_ratio(4'h0);
    wr_stat(1'b0, 2'h3);
    tick(LC + 6);
    chk(cfg, {pcm_pkg::PCM_BYPASS, 4'h0, pcm_pkg::DIV_BY_1});
    $display("test bypass done");
    wr_stat(1'b1, 2'h3);
    tick(4);
    chk(cfg, {pcm_pkg::PCM_OFF, 4'h0, pcm_pkg::DIV_BY_1});
    chk({lock, powered}, 16'h0000);
    $display("test power down done");
    ext_req <= 1'b1;
    tick(6);
    chk(osc_en, 16'h0000);
    ext_req <= 1'b0;
    tick(6);
    chk(osc_en, 16'h0001);
    $display("test clock source done");
    @(posedge clk);
    do_reset();
    test_done();
  end
endmodule

//--- pcm_lock_counter.sv
// Lock settle counter of the PLL clock control block.
// Assumes restart and enable come from logic on clk.
`timescale 1ns/1ps
module pcm_lock_counter #(
  parameter int unsigned COUNT = pcm_pkg::LOCK_OSC_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic restart,
  input  wire logic enable,
  output logic      locked
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          locked_reg;
  logic          locked_next;

  always_comb begin
    count_next  = count_reg;
    locked_next = locked_reg;
    if (restart) begin
      count_next  = '0;
      locked_next = 1'b0;
    end else if (enable && !locked_reg) begin
      count_next = count_reg + CW'(1);
      if (count_reg == LAST) begin
        locked_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg  <= '0;
      locked_reg <= 1'b0;
    end else begin
      count_reg  <= count_next;
      locked_reg <= locked_next;
    end
  end

  assign locked = locked_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  lock_on_count_a: assert property (
    $rose(locked_reg) |-> $past(count_reg) == LAST && !$past(restart))
    else $error("lock set before full settle count");

endmodule

//--- pcm_osc_model.sv
// Oscillator source model: crystal or external clock on the pins.
// Assumes the bench picks the source; the level is a static strap.
`timescale 1ns/1ps
module pcm_osc_model (
  input  wire logic source_is_external,
  output logic      external_clock_select
);
  // Strap level only, the oscillator itself is the bench clock
  assign external_clock_select = source_is_external;
endmodule

//--- pcm_pkg.sv
// Shared constants and types of the PLL clock control block.
// Assumes one clock, clk, taken as the oscillator clock itself.
package pcm_pkg;

  localparam int unsigned LOCK_OSC_CYCLES = 131072;

  localparam logic [3:0] RATIO_RESET  = 4'h0;
  localparam logic [3:0] RATIO_BYPASS = 4'h0;
  localparam logic [3:0] RATIO_MAX    = 4'hA;

  localparam logic [1:0] POSTDIV_RESET = 2'h0;
  localparam logic [1:0] POSTDIV_DIV2  = 2'h2;
  localparam logic [1:0] POSTDIV_DIV1  = 2'h3;

  localparam logic [2:0] DIV_BY_4 = 3'h4;
  localparam logic [2:0] DIV_BY_2 = 3'h2;
  localparam logic [2:0] DIV_BY_1 = 3'h1;

  localparam logic PWRDN_RESET = 1'b0;

  typedef struct packed {
    logic       pll_power_down_bit;
    logic [1:0] post_divider_select;
  } pcm_status_type;

  typedef enum logic [3:0] {
    PCM_OFF     = 4'h1,
    PCM_BYPASS  = 4'h2,
    PCM_LOCKING = 4'h4,
    PCM_ENABLED = 4'h8
  } pcm_mode_type;

  typedef struct packed {
    pcm_mode_type mode;
    logic [3:0]   multiplier;
    logic [2:0]   divider;
  } pcm_clock_cfg_type;

endpackage
